// *** pdst_pkg.sv ***
// Package: register map, field positions, reset values and carriers for the PHY status/10BT block
package pdst_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [4:0] PDST_ADDR_DETAILED_STATUS = 5'h11;
    localparam logic [4:0] PDST_ADDR_TENBT_OPS       = 5'h12;
    localparam logic [4:0] PDST_ADDR_VENDOR_FIRST    = 5'h19;
    localparam logic [4:0] PDST_ADDR_VENDOR_LAST     = 5'h1f;

    // ************************************************************
    // Detailed status field positions
    // ************************************************************
    localparam int PDST_DS_PROGRESS_B0  = 11;
    localparam int PDST_DS_SIGNAL_LOST  = 10;
    localparam int PDST_DS_PLL_ERROR    = 9;
    localparam int PDST_DS_FALSE_CARR   = 8;
    localparam int PDST_DS_INVALID_SYM  = 7;
    localparam int PDST_DS_HALT_SYM     = 6;
    localparam int PDST_DS_PREMATURE    = 5;
    localparam int PDST_DS_ANEG_DONE    = 4;
    localparam int PDST_DS_SIGNAL_ABS   = 3;
    localparam int PDST_DS_JABBER       = 2;
    localparam int PDST_DS_REMOTE_FAULT = 1;
    localparam int PDST_DS_LINK         = 0;

    // ************************************************************
    // 10Base-T operations field positions
    // ************************************************************
    localparam int PDST_OP_REMOTE_JAB   = 15;
    localparam int PDST_OP_POL_REV      = 14;
    localparam int PDST_OP_BUS_MODE_HI  = 13;
    localparam int PDST_OP_BUS_MODE_LO  = 12;
    localparam int PDST_OP_AUTO_XOVER   = 11;
    localparam int PDST_OP_RX_TRI       = 10;
    localparam int PDST_OP_VENDOR_GATE  = 9;
    localparam int PDST_OP_TEST_PATH    = 8;
    localparam int PDST_OP_RSV7         = 7;
    localparam int PDST_OP_RSV6         = 6;
    localparam int PDST_OP_JAB_INHIBIT  = 5;
    localparam int PDST_OP_RSV4         = 4;
    localparam int PDST_OP_APOL_INHIBIT = 3;
    localparam int PDST_OP_SQE_INHIBIT  = 2;
    localparam int PDST_OP_LLOSS_INHIB  = 1;
    localparam int PDST_OP_SQL_INHIBIT  = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] PDST_OPS_FIXED_RST = 16'h0010;
    localparam logic [11:0] PDST_FLAGS_RST     = 12'h000;
    localparam logic [1:0]  PDST_BUS_MII       = 2'h0;
    localparam logic [1:0]  PDST_BUS_SERIAL    = 2'h1;

    // Number of latching-high event flags
    localparam int PDST_NUM_LH = 10;

    // ************************************************************
    // Carriers
    // ************************************************************
    // Management access from the serial-management front end
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pdst_mgmt_req_t;

    // Physical-layer event and condition levels
    typedef struct packed {
        logic       signal_lost;
        logic       pll_error;
        logic       false_carrier;
        logic       invalid_symbol;
        logic       halt_symbol;
        logic       premature_end;
        logic       jabber;
        logic       remote_fault;
        logic       remote_jabber;
        logic       polarity_reversed;
        logic       link_valid;
        logic       aneg_done;
        logic       signal_absent;
        logic       progress_b0;
    } pdst_phy_evt_t;

    // Controls steering the physical-layer logic
    typedef struct packed {
        logic auto_crossover_enable;
        logic receive_output_tristate;
        logic vendor_register_gate;
        logic test_path_select;
        logic jabber_inhibit;
        logic auto_polarity_inhibit;
        logic sqe_test_inhibit;
        logic link_loss_inhibit;
        logic squelch_inhibit;
    } pdst_ctrl_t;

endpackage

// *** pdst_regs.sv ***
// Detailed status and 10Base-T operations registers of the PHY management block
`timescale 1ns/1ns

module pdst_regs (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // Reset-time straps from pins
    input  wire logic [1:0]              strap_bus_mode,
    input  wire logic                    strap_rx_tristate,
    input  wire logic                    strap_vendor_gate,
    input  wire logic                    strap_auto_xover,
    // Management access
    input  wire pdst_pkg::pdst_mgmt_req_t mgmt_req,
    output logic [15:0]                  mgmt_rdata,
    output logic                         mgmt_vendor_access,
    // Physical-layer conditions
    input  wire pdst_pkg::pdst_phy_evt_t phy_evt,
    // Controls and effects
    output pdst_pkg::pdst_ctrl_t         ctrl,
    output logic                         rx_out_enable,
    output logic                         link_pass_forced,
    output logic                         polarity_correct_en,
    output logic                         sqe_test_en,
    output logic                         test_path_one_sel,
    output logic                         test_path_two_sel
);
    import pdst_pkg::*;

    // ************************************************************
    // Strap synchronisers and capture after reset release
    // ************************************************************
    // Stages run without reset so the straps are settled when reset lets go
    logic [4:0] strap_pin;
    logic [4:0] strap_s1_ff;
    logic [4:0] strap_s2_ff;
    logic [4:0] strap_s3_ff;
    logic [4:0] strap_sync_ff;
    logic [4:0] nxt_strap_sync;
    logic [4:0] strap_agree;
    logic       strap_done_ff;
    logic [1:0] bus_mode_ff;

    assign strap_pin      = {strap_bus_mode, strap_rx_tristate, strap_vendor_gate, strap_auto_xover};
    assign strap_agree    = ~(strap_s2_ff ^ strap_s3_ff);
    // A bit only moves once the last two stages agree, so one odd sample is ignored
    assign nxt_strap_sync = (strap_s3_ff & strap_agree) | (strap_sync_ff & ~strap_agree);

    // Limitation: straps must stand for four clocks of reset before release
    always_ff @(posedge clk_sys) begin
        strap_s1_ff   <= strap_pin;
        strap_s2_ff   <= strap_s1_ff;
        strap_s3_ff   <= strap_s2_ff;
        strap_sync_ff <= nxt_strap_sync;
    end

    // ************************************************************
    // Access decode
    // ************************************************************
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    wire rd_status = mgmt_req.rd & addr_is(mgmt_req.addr, PDST_ADDR_DETAILED_STATUS);
    wire rd_ops    = mgmt_req.rd & addr_is(mgmt_req.addr, PDST_ADDR_TENBT_OPS);
    wire wr_ops    = mgmt_req.wr & addr_is(mgmt_req.addr, PDST_ADDR_TENBT_OPS);
    wire vendor_hit = (mgmt_req.addr >= PDST_ADDR_VENDOR_FIRST) && (mgmt_req.addr <= PDST_ADDR_VENDOR_LAST);

    // ************************************************************
    // Latching flags
    // ************************************************************
    // Index order: 9 remote jabber, 8 polarity, then status flags
    logic [PDST_NUM_LH-1:0] lh_ff;
    logic [PDST_NUM_LH-1:0] lh_cond;
    logic [PDST_NUM_LH-1:0] lh_clr;
    logic                   link_ff;

    assign lh_cond = {phy_evt.remote_jabber, phy_evt.polarity_reversed,
                      phy_evt.signal_lost, phy_evt.pll_error, phy_evt.false_carrier,
                      phy_evt.invalid_symbol, phy_evt.halt_symbol, phy_evt.premature_end,
                      phy_evt.jabber, phy_evt.remote_fault};
    assign lh_clr  = {{2{rd_ops}}, {8{rd_status}}};

    genvar gi;
    generate
        for (gi = 0; gi < PDST_NUM_LH; gi++) begin : g_lh
            // Event in the clearing read cycle wins, so nothing is lost
            wire nxt_lh = lh_cond[gi] | (lh_ff[gi] & ~lh_clr[gi]);
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    lh_ff[gi] <= 1'b0;
                end else begin
                    lh_ff[gi] <= nxt_lh;
                end
            end
        end
    endgenerate

    // Latch-low: loss holds zero until read, then follows the link
    wire nxt_link = phy_evt.link_valid & (link_ff | rd_status);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            link_ff <= 1'b0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    // ************************************************************
    // Operations control register
    // ************************************************************
    logic [15:0] ops_ff;
    logic [15:0] nxt_ops;
    logic [15:0] ops_strap_word;

    // Read-only and reserved-fixed bits never take write data
    localparam logic [15:0] OPS_WR_MASK = 16'h0f2f;

    always_comb begin
        ops_strap_word                      = PDST_OPS_FIXED_RST;
        ops_strap_word[PDST_OP_AUTO_XOVER]  = strap_sync_ff[0];
        ops_strap_word[PDST_OP_RX_TRI]      = strap_sync_ff[2];
        ops_strap_word[PDST_OP_VENDOR_GATE] = strap_sync_ff[1];
    end

    // Writes on the strap-capture edge are dropped in favour of the straps
    assign nxt_ops = !strap_done_ff ? ops_strap_word
                   : wr_ops ? ((mgmt_req.wdata & OPS_WR_MASK) | (ops_ff & ~OPS_WR_MASK))
                   : ops_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strap_done_ff <= 1'b0;
            bus_mode_ff   <= PDST_BUS_MII;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            bus_mode_ff   <= strap_sync_ff[4:3];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ops_ff <= PDST_OPS_FIXED_RST;
        end else begin
            ops_ff <= nxt_ops;
        end
    end

    // ************************************************************
    // Read data and control outputs
    // ************************************************************
    logic [15:0] status_word;

    // Upper four status bits are not modelled here and read zero
    always_comb begin
        status_word                       = 16'h0000;
        status_word[PDST_DS_PROGRESS_B0]  = phy_evt.progress_b0;
        status_word[PDST_DS_SIGNAL_LOST]  = lh_ff[7];
        status_word[PDST_DS_PLL_ERROR]    = lh_ff[6];
        status_word[PDST_DS_FALSE_CARR]   = lh_ff[5];
        status_word[PDST_DS_INVALID_SYM]  = lh_ff[4];
        status_word[PDST_DS_HALT_SYM]     = lh_ff[3];
        status_word[PDST_DS_PREMATURE]    = lh_ff[2];
        status_word[PDST_DS_ANEG_DONE]    = phy_evt.aneg_done;
        status_word[PDST_DS_SIGNAL_ABS]   = phy_evt.signal_absent;
        status_word[PDST_DS_JABBER]       = lh_ff[1];
        status_word[PDST_DS_REMOTE_FAULT] = lh_ff[0];
        status_word[PDST_DS_LINK]         = link_ff;
    end

    wire [15:0] ops_word    = {lh_ff[9:8],
                               bus_mode_ff,
                               ops_ff[11:0]};
    // Reads of other addresses leave the last word standing
    wire [15:0] nxt_rdata   = rd_status ? status_word : (rd_ops ? ops_word : mgmt_rdata);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mgmt_rdata <= 16'h0000;
        end else begin
            mgmt_rdata <= nxt_rdata;
        end
    end

    assign ctrl.auto_crossover_enable   = ops_ff[PDST_OP_AUTO_XOVER];
    assign ctrl.receive_output_tristate = ops_ff[PDST_OP_RX_TRI];
    assign ctrl.vendor_register_gate    = ops_ff[PDST_OP_VENDOR_GATE];
    assign ctrl.test_path_select        = ops_ff[PDST_OP_TEST_PATH];
    assign ctrl.jabber_inhibit          = ops_ff[PDST_OP_JAB_INHIBIT];
    assign ctrl.auto_polarity_inhibit   = ops_ff[PDST_OP_APOL_INHIBIT];
    assign ctrl.sqe_test_inhibit        = ops_ff[PDST_OP_SQE_INHIBIT];
    assign ctrl.link_loss_inhibit       = ops_ff[PDST_OP_LLOSS_INHIB];
    assign ctrl.squelch_inhibit         = ops_ff[PDST_OP_SQL_INHIBIT];

    assign rx_out_enable       = ~ops_ff[PDST_OP_RX_TRI];
    assign mgmt_vendor_access  = (mgmt_req.rd | mgmt_req.wr) & vendor_hit
                                 & ~ops_ff[PDST_OP_VENDOR_GATE];
    assign link_pass_forced    = ops_ff[PDST_OP_LLOSS_INHIB];
    assign polarity_correct_en = ~ops_ff[PDST_OP_APOL_INHIBIT];
    assign sqe_test_en         = ~ops_ff[PDST_OP_SQE_INHIBIT];
    assign test_path_one_sel   = ~ops_ff[PDST_OP_TEST_PATH];
    assign test_path_two_sel   = ops_ff[PDST_OP_TEST_PATH];

endmodule

// *** pdst_regs_props.sv ***
// Checker: concurrent properties on the ports of the status and 10Base-T operations registers
`timescale 1ns/1ns

module pdst_regs_props (
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    reset,
    // Management side
    input wire logic [1:0]              strap_bus_mode,
    input wire pdst_pkg::pdst_mgmt_req_t mgmt_req,
    input wire logic [15:0]             mgmt_rdata,
    input wire logic                    mgmt_vendor_access,
    // Physical-layer side
    input wire pdst_pkg::pdst_phy_evt_t phy_evt,
    input wire pdst_pkg::pdst_ctrl_t    ctrl,
    input wire logic                    rx_out_enable,
    input wire logic                    link_pass_forced,
    input wire logic                    polarity_correct_en,
    input wire logic                    sqe_test_en
);
    import pdst_pkg::*;
    logic rd_st;
    logic rd_op;
    assign rd_st = mgmt_req.rd && (mgmt_req.addr == PDST_ADDR_DETAILED_STATUS);
    assign rd_op = mgmt_req.rd && (mgmt_req.addr == PDST_ADDR_TENBT_OPS);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ****************
    // Properties
    // ****************
    property p_vend; mgmt_vendor_access == ((mgmt_req.rd || mgmt_req.wr) && !ctrl.vendor_register_gate
        && (mgmt_req.addr >= PDST_ADDR_VENDOR_FIRST)); endproperty
    a_vend: assert property (p_vend) else $error("vendor access gating wrong");
    property p_rxt; rx_out_enable != ctrl.receive_output_tristate; endproperty
    a_rxt: assert property (p_rxt) else $error("receive enable wrong");
    property p_lpass; link_pass_forced == ctrl.link_loss_inhibit; endproperty
    a_lpass: assert property (p_lpass) else $error("link pass wrong");
    property p_pol; polarity_correct_en != ctrl.auto_polarity_inhibit; endproperty
    a_pol: assert property (p_pol) else $error("polarity correction wrong");
    property p_sqe; sqe_test_en != ctrl.sqe_test_inhibit; endproperty
    a_sqe: assert property (p_sqe) else $error("quality test enable wrong");
    property p_fc; rd_st && !$past(reset) && $past(phy_evt.false_carrier) |=> mgmt_rdata[8]; endproperty
    a_fc: assert property (p_fc) else $error("false carrier not latched");
    property p_hs; rd_st && !$past(reset) && $past(phy_evt.halt_symbol) |=> mgmt_rdata[6]; endproperty
    a_hs: assert property (p_hs) else $error("halt flag not latched");
    property p_rf; rd_st && !$past(reset) && $past(phy_evt.remote_fault) |=> mgmt_rdata[1]; endproperty
    a_rf: assert property (p_rf) else $error("remote fault not latched");
    property p_rj; rd_op && !$past(reset) && $past(phy_evt.remote_jabber) |=> mgmt_rdata[15]; endproperty
    a_rj: assert property (p_rj) else $error("remote jabber not latched");
    property p_link; rd_st && !$past(reset) && !$past(phy_evt.link_valid) |=> !mgmt_rdata[0]; endproperty
    a_link: assert property (p_link) else $error("link loss not latched");
    property p_mode; rd_op |=> mgmt_rdata[13:12] == $past(strap_bus_mode); endproperty
    a_mode: assert property (p_mode) else $error("bus mode wrong");
endmodule

bind pdst_regs pdst_regs_props u_props (.clk_sys(clk_sys), .reset(reset), .strap_bus_mode(strap_bus_mode),
    .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_vendor_access(mgmt_vendor_access), .phy_evt(phy_evt),
    .ctrl(ctrl), .rx_out_enable(rx_out_enable), .link_pass_forced(link_pass_forced),
    .polarity_correct_en(polarity_correct_en), .sqe_test_en(sqe_test_en));

// *** pdst_sta_model.sv ***
// Station management model: one-word register transfers towards the block
`timescale 1ns/1ns

module pdst_sta_model (
    // Clock
    input  wire logic                    clk_sys,
    // Answers
    input  wire logic [15:0]             mgmt_rdata,
    input  wire logic                    mgmt_vendor_access,
    // Requests
    output pdst_pkg::pdst_mgmt_req_t     mgmt_req
);
    import pdst_pkg::*;
    initial mgmt_req = '0;
    // Entered just after a rising edge; random idle keeps both prompt and slow spacing
    task automatic xfer(input logic r, input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic va);
        repeat ($urandom % 2) @(posedge clk_sys);
        mgmt_req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(negedge clk_sys);
        va = mgmt_vendor_access;
        @(posedge clk_sys);
        mgmt_req.rd <= 1'b0;
        mgmt_req.wr <= 1'b0;
        @(negedge clk_sys);
        q = mgmt_rdata;
        @(posedge clk_sys);
    endtask
endmodule

// *** phy_detail_status_10bt_ctrl_bench.sv ***
// Testbench: random and corner-case management traffic against the status and operations registers
`timescale 1ns/1ns

module phy_detail_status_10bt_ctrl_bench;
    import pdst_pkg::*;
    logic           clk_sys = 1'b0;
    logic           reset = 1'b1;
    pdst_mgmt_req_t mgmt_req;
    pdst_phy_evt_t  phy_evt = '0;
    pdst_ctrl_t     ctrl;
    logic [15:0]    mgmt_rdata, q, w, ops_exp, base;
    logic           mgmt_vendor_access, va, rx_en, lpass, pol_en, sqe_en, tp1, tp2;
    logic [4:0]     a;
    logic [1:0]     s_mode = 2'h1;
    logic           s_rx = 1'b1;
    logic           s_gate = 1'b0;
    logic           s_xo = 1'b1;
    int             err_total = 0;
    int             cmp_count = 0;
    int             pos[10] = '{10, 9, 8, 7, 6, 5, 2, 1, 15, 14};
    always #20 clk_sys = ~clk_sys;
    pdst_regs dut (.clk_sys(clk_sys), .reset(reset), .strap_bus_mode(s_mode), .strap_rx_tristate(s_rx),
        .strap_vendor_gate(s_gate), .strap_auto_xover(s_xo), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_vendor_access(mgmt_vendor_access), .phy_evt(phy_evt), .ctrl(ctrl), .rx_out_enable(rx_en),
        .link_pass_forced(lpass), .polarity_correct_en(pol_en), .sqe_test_en(sqe_en),
        .test_path_one_sel(tp1), .test_path_two_sel(tp2));
    pdst_sta_model sta (.clk_sys(clk_sys), .mgmt_rdata(mgmt_rdata), .mgmt_vendor_access(mgmt_vendor_access),
        .mgmt_req(mgmt_req));
    function automatic logic [15:0] ops_wr(input logic [15:0] o, input logic [15:0] d);
        return (o & ~16'h0f2f) | (d & 16'h0f2f);
    endfunction
    function automatic logic vend_exp(input logic [4:0] ad, input logic gate);
        return (ad >= PDST_ADDR_VENDOR_FIRST) && !gate;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        results();
    end
    initial begin
        void'($urandom(95932));
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ops_exp = 16'h1c10;
        sta.xfer(1'b1, 1'b0, PDST_ADDR_TENBT_OPS, 16'h0000, q, va);
        chk("ops_reset", ops_exp, q);
        chk("rx_enable", 16'h0000, {15'h0, rx_en});
        // ****************
        // Random control writes, gate and vendor window
        // ****************
        for (int i = 0; i < 24; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            sta.xfer(1'b0, 1'b1, PDST_ADDR_TENBT_OPS, w, q, va);
            ops_exp = ops_wr(ops_exp, w);
            sta.xfer(1'b1, 1'b0, PDST_ADDR_TENBT_OPS, 16'h0000, q, va);
            chk("ops", ops_exp, q);
            chk("ctl", {10'h0, ~ops_exp[10], ops_exp[1], ~ops_exp[3], ~ops_exp[2], ~ops_exp[8], ops_exp[8]},
                {10'h0, rx_en, lpass, pol_en, sqe_en, tp1, tp2});
            chk("ctrl", {7'h0, ops_exp[11:8], ops_exp[5], ops_exp[3:0]}, {7'h0, ctrl});
            a = 5'h13 + 5'($urandom % 13);
            sta.xfer(i[0], ~i[0], a, w, q, va);
            chk("vendor", {15'h0, vend_exp(a, ops_exp[9])}, {15'h0, va});
        end
        sta.xfer(1'b0, 1'b1, PDST_ADDR_DETAILED_STATUS, 16'hffff, q, va);
        sta.xfer(1'b1, 1'b0, PDST_ADDR_DETAILED_STATUS, 16'h0000, q, va);
        chk("status_ro", 16'h0000, q);
        // ****************
        // One-cycle events latch until read
        // ****************
        for (int i = 0; i < 10; i++) begin
            a = (i < 8) ? PDST_ADDR_DETAILED_STATUS : PDST_ADDR_TENBT_OPS;
            base = (i < 8) ? 16'h0000 : ops_exp;
            phy_evt <= pdst_phy_evt_t'(14'h1 << (13 - i));
            @(posedge clk_sys);
            phy_evt <= '0;
            sta.xfer(1'b1, 1'b0, a, 16'h0000, q, va);
            chk("flag_set", base | (16'h1 << pos[i]), q);
            sta.xfer(1'b1, 1'b0, a, 16'h0000, q, va);
            chk("flag_clear", base, q);
        end
        // ****************
        // Events held across reads: the set beats the clearing read
        // ****************
        phy_evt <= 14'h0a60;
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) phy_evt <= '0;
            sta.xfer(1'b1, 1'b0, PDST_ADDR_DETAILED_STATUS, 16'h0000, q, va);
            chk("flag_hold", (k < 3) ? 16'h0142 : 16'h0000, q);
            sta.xfer(1'b1, 1'b0, PDST_ADDR_TENBT_OPS, 16'h0000, q, va);
            chk("jab_hold", (k < 3) ? (ops_exp | 16'h8000) : ops_exp, q);
        end
        // Link latched low, live bits follow their levels
        phy_evt <= 14'h000f;
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                phy_evt.link_valid <= 1'b0;
                @(posedge clk_sys);
                phy_evt.link_valid <= 1'b1;
            end
            sta.xfer(1'b1, 1'b0, PDST_ADDR_DETAILED_STATUS, 16'h0000, q, va);
            chk("link_low", 16'h0818, q);
            sta.xfer(1'b1, 1'b0, PDST_ADDR_DETAILED_STATUS, 16'h0000, q, va);
            chk("link_up", 16'h0819, q);
        end
        // ****************
        // Second reset in mid-run with the other strap settings
        // ****************
        reset  <= 1'b1;
        s_mode <= 2'h0;
        s_rx   <= 1'b0;
        s_gate <= 1'b1;
        s_xo   <= 1'b0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ops_exp = 16'h0210;
        sta.xfer(1'b1, 1'b0, PDST_ADDR_TENBT_OPS, 16'h0000, q, va);
        chk("ops_strap", ops_exp, q);
        chk("rx_enable_strap", 16'h0001, {15'h0, rx_en});
        sta.xfer(1'b1, 1'b0, PDST_ADDR_VENDOR_FIRST, 16'h0000, q, va);
        chk("vendor_strap", {15'h0, vend_exp(PDST_ADDR_VENDOR_FIRST, ops_exp[9])}, {15'h0, va});
        results();
    end
endmodule
